// ===== bench/csrd_seq_model.sv
// csrd_seq_model: microprogram sequencer side of the read decode.
// assumes the phase output of the store; drives on the falling edge.
`timescale 1ns/1ps
module csrd_seq_model
    import csrd_pkg::*;
(
    input wire logic clk_i, // store clock
    input wire logic [1:0] phase_i, // store cycle phase
    input wire logic [ADDR_W-1:0] addr_i, // next word to fetch
    output logic [0:7] high_o, // high address register
    output logic [0:7] low_o // low address register
);
    initial begin
        high_o = 8'h00;
        low_o = 8'h00;
    end

    // outside the load phase the lines toggle, so late sampling shows
    always @(negedge clk_i) begin
        if (phase_i == 2'h0) begin
            high_o <= {3'h0, addr_i[12:8]};
            low_o <= addr_i[7:0];
        end else begin
            high_o <= ~high_o;
            low_o <= ~low_o;
        end
    end
endmodule

// ===== bench/csrd_tb_top.sv
// csrd_tb_top: self-checking bench for the control store read decode.
// assumes the whole store is written before any word is judged.
`timescale 1ns/1ps
module csrd_tb_top
    import csrd_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic [ADDR_W-1:0] wr_addr = 13'h0000;
    logic [0:WORD_W-1] punch = WORD_RST;
    logic [ADDR_W-1:0] seq_addr = 13'h0000;
    logic [0:7] hi;
    logic [0:7] lo;
    logic [0:WORD_W-1] latch;
    logic [0:CREG_W-1] creg;
    logic [1:0] phase;
    logic [BOARD_W-1:0] board;
    logic [DRV_GATES-1:0] gate;
    logic [ROW_LINES-1:0] row;
    logic module_sel;
    logic fault;
    logic [0:WORD_W-1] prev;
    logic prev_ok = 1'b0;
    int fails = 0;
    int checks = 0;
    int cyc = 0;

    always #5 clk = ~clk;

    csrd_seq_model u_csrd_seq_model (.clk_i(clk), .phase_i(phase),
        .addr_i(seq_addr), .high_o(hi), .low_o(lo));

    csrd_top u_csrd_top (.CLK_I(clk), .RST_I(rst), .ADDR_HIGH_I(hi),
        .ADDR_LOW_I(lo), .CARD_WR_I(wr), .CARD_ADDR_I(wr_addr),
        .CARD_PUNCH_I(punch), .LATCH_O(latch), .CTRL_REG_O(creg),
        .PHASE_O(phase), .BOARD_O(board), .GATE_O(gate), .ROW_SEL_O(row),
        .MODULE_O(module_sel), .DRIVE_FAULT_O(fault));

    // content differs between the two words of every pair
    function automatic logic [0:WORD_W-1] pat(input logic [ADDR_W-1:0] a);
        return {a, ~a, a, ~a, 8'h5A};
    endfunction

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] s,
                       input logic [63:0] x);
        checks++;
        if (s !== x) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic wait_ph(input logic [1:0] p);
        int n;
        n = 0;
        @(negedge clk);
        while (phase !== p && n < 8) begin
            @(negedge clk);
            n++;
        end
    endtask

    // entered at a phase-four falling edge, leaves at the next one
    task automatic rd(input logic [ADDR_W-1:0] a);
        logic [0:WORD_W-1] e;
        int off;
        off = int'(a[11:0]);
        e = (off < MOD_LAST + 1) ? ~pat(a) : WORD_RST;
        seq_addr = a;
        wait_ph(2'h0);
        if (prev_ok) chk("latch held", 64'(latch), 64'(prev));
        wait_ph(2'h1);
        chk("ctrl clear", 64'(creg), 64'h0);
        if (prev_ok) chk("latch kept", 64'(latch), 64'(prev));
        wait_ph(2'h2);
        chk("latch reset", 64'(latch), 64'h0);
        wait_ph(2'h3);
        chk("word", 64'(latch), 64'(e));
        if (prev_ok) begin
            chk("ctrl", 64'(creg), 64'(prev[CREG_LO:CREG_HI]));
        end
        chk("module", 64'(module_sel), 64'(a[12]));
        chk("fault", 64'(fault), 64'h0);
        if (off <= MOD_LAST) begin
            chk("board", 64'(board), 64'(off / BOARD_WORDS));
            chk("gate", 64'(gate), 64'(3'h1 << ((off / 32) % 3)));
            chk("row", 64'(row), 64'(16'h0001 << ((off >> 1) % 16)));
        end else begin
            chk("no gate", 64'(gate), 64'h0);
        end
        prev = e;
        prev_ok = 1'b1;
    endtask

    task automatic t_pairs();
        rd(13'd0);
        rd(13'd1);
        rd(13'd62);
        rd(13'd63);
        $display("pairs done");
    endtask

    task automatic t_boards();
        rd(13'd95);
        rd(13'd96);
        rd(13'd3937);
        rd(13'd4030);
        rd(13'd4031);
        $display("boards done");
    endtask

    task automatic t_rows();
        for (int r = 0; r < ROW_LINES; r++) begin
            rd(13'(64 + 2 * r + r % 2));
        end
        $display("rows done");
    endtask

    task automatic t_module2();
        rd(13'd4096);
        rd(13'd31);
        rd(13'd4097);
        rd(13'd8127);
        $display("second module done");
    endtask

    task automatic t_unmapped();
        rd(13'd4032);
        rd(13'd4095);
        rd(13'd8128);
        rd(13'd5);
        $display("unmapped done");
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            fails++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // store is not reset, so every position is set first
        for (int i = 0; i < STORE_DEPTH; i++) begin
            wr = 1'b1;
            wr_addr = 13'(i);
            punch = pat(13'(i));
            @(negedge clk);
        end
        wr = 1'b0;
        wait_ph(2'h3);
        t_pairs();
        t_boards();
        t_rows();
        t_module2();
        t_unmapped();
        results();
    end
endmodule

// ===== rtl/csrd_decode.sv
// csrd_decode: address decode network of one 4K module.
// assumes address bits are stable registered values on the same clock.
`timescale 1ns/1ps
module csrd_decode
    import csrd_pkg::*;
(
    input wire logic enable_i, // this module selected
    input wire logic readout_i, // readout time
    input wire logic [0:7] high_i, // high address register
    input wire logic [0:7] low_i, // low address register
    output logic [ROW_LINES-1:0] row_o, // row-select lines
    output logic [DRV_GATES-1:0] gate_o, // driver gate, one-hot
    output logic [BOARD_W-1:0] board_o, // board of the active gate
    output logic hit_o // one driver energised
);

    logic gate_ro_a;
    logic gate_ro_b;
    logic [7:0] a_line;
    logic [3:0] b_line;
    logic [3:0] c_line;
    logic [6:0] kk;
    logic term;

    assign gate_ro_a = enable_i & readout_i & ~low_i[LO_HALF_BIT];
    assign gate_ro_b = enable_i & readout_i & low_i[LO_HALF_BIT];

    always_comb begin
        row_o = ROW_RST;
        for (int r = 0; r < ROW_LINES / 2; r++) begin
            row_o[r] = gate_ro_a & (low_i[4:6] == 3'(r));
            row_o[r + 8] = gate_ro_b & (low_i[4:6] == 3'(r));
        end
    end

    always_comb begin
        a_line = 8'h00;
        b_line = 4'h0;
        c_line = 4'h0;
        a_line[low_i[0:2]] = 1'b1;
        b_line[high_i[6:7]] = 1'b1;
        c_line[high_i[4:5]] = 1'b1;
    end

    // unused table slots past board 41 never open a gate
    always_comb begin
        gate_o = GATE_RST;
        board_o = BOARD_RST;
        hit_o = 1'b0;
        kk = 7'h00;
        term = 1'b0;
        for (int k = 0; k < TBL_DEPTH; k++) begin
            kk = 7'(k);
            term = c_line[kk[6:5]] & b_line[kk[4:3]] & a_line[kk[2:0]]
                & GATE_TBL[k][TBL_VALID_BIT] & (|row_o);
            if (term) begin
                board_o = GATE_TBL[k][TBL_BOARD_HI:TBL_BOARD_LO];
                gate_o[GATE_TBL[k][TBL_GATE_HI:TBL_GATE_LO]] = 1'b1;
                hit_o = 1'b1;
            end
        end
    end

endmodule

// ===== rtl/csrd_pkg.sv
// csrd_pkg: constants, phase type and board/gate table for the
// control store read decode block.
// assumes one 100 MHz clock; one machine cycle is four clock phases.
package csrd_pkg;

    localparam int WORD_W = 60;
    localparam int ADDR_W = 13;
    localparam int STORE_DEPTH = 8192;
    localparam int BOARD_WORDS = 96;
    localparam int NUM_BOARDS = 42;
    localparam int BOARD_DRIVERS = 48;
    localparam int ROW_LINES = 16;
    localparam int DRV_GATES = 3;
    localparam int GATE_DRIVERS = 16;
    localparam int MOD_LAST = 4031;
    localparam int MOD2_BASE = 4096;
    localparam int MOD2_LAST = 8127;
    localparam int CREG_LO = 34;
    localparam int CREG_HI = 51;
    localparam int CREG_W = CREG_HI - CREG_LO + 1;
    localparam int TBL_DEPTH = 128;
    localparam int BOARD_W = 6;

    // field positions inside one table entry
    localparam int TBL_VALID_BIT = 8;
    localparam int TBL_BOARD_HI = 7;
    localparam int TBL_BOARD_LO = 2;
    localparam int TBL_GATE_HI = 1;
    localparam int TBL_GATE_LO = 0;

    // address register bit positions, bit 0 is the most significant
    localparam int HI_MODULE_BIT = 3;
    localparam int LO_HALF_BIT = 3;
    localparam int LO_WORD_BIT = 7;

    // reset values
    localparam logic [0:7] ADDR_RST = 8'h00;
    localparam logic [0:WORD_W-1] WORD_RST = 60'h000000000000000;
    localparam logic [0:CREG_W-1] CREG_RST = 18'h00000;
    localparam logic [BOARD_W-1:0] BOARD_RST = 6'h00;
    localparam logic [DRV_GATES-1:0] GATE_RST = 3'h0;
    localparam logic [ROW_LINES-1:0] ROW_RST = 16'h0000;

    typedef enum logic [1:0] {
        PH_ONE,
        PH_TWO,
        PH_THREE,
        PH_FOUR
    } csrd_phase_e;

    typedef logic [8:0] csrd_tbl_t [0:TBL_DEPTH-1];

    // index is {c group, b group, a group}; 96 = 3 x 32 keeps it linear
    function automatic csrd_tbl_t csrd_build_tbl();
        csrd_tbl_t t;
        for (int k = 0; k < TBL_DEPTH; k++) begin
            if (k < NUM_BOARDS * DRV_GATES) begin
                t[k] = {1'b1, 6'(k / DRV_GATES), 2'(k % DRV_GATES)};
            end else begin
                t[k] = 9'h000;
            end
        end
        return t;
    endfunction

    localparam csrd_tbl_t GATE_TBL = csrd_build_tbl();

endpackage

// ===== rtl/csrd_top.sv
// csrd_top: read side of a two-module microprogram control store.
// assumes the sequencer presents the next word address, on this clock,
// during the first phase of every machine cycle.
`timescale 1ns/1ps
module csrd_top
    import csrd_pkg::*;
(
    input wire logic CLK_I, // 100 MHz clock
    input wire logic RST_I, // asynchronous reset, active high
    input wire logic [0:7] ADDR_HIGH_I, // next address, high register
    input wire logic [0:7] ADDR_LOW_I, // next address, low register
    input wire logic CARD_WR_I, // write one word position set
    input wire logic [ADDR_W-1:0] CARD_ADDR_I, // word to write
    input wire logic [0:WORD_W-1] CARD_PUNCH_I, // one per removed bit
    output logic [0:WORD_W-1] LATCH_O, // word sense latches
    output logic [0:CREG_W-1] CTRL_REG_O, // control registers
    output logic [1:0] PHASE_O, // current cycle phase
    output logic [BOARD_W-1:0] BOARD_O, // last board read
    output logic [DRV_GATES-1:0] GATE_O, // last driver gate used
    output logic [ROW_LINES-1:0] ROW_SEL_O, // last row line used
    output logic MODULE_O, // last module used
    output logic DRIVE_FAULT_O // both modules driving, or row lines not one-hot
);

    csrd_phase_e phase_reg;
    csrd_phase_e phase_next;
    logic [0:7] addr_high_reg;
    logic [0:7] addr_low_reg;
    logic [0:WORD_W-1] store [0:STORE_DEPTH-1];
    logic [0:WORD_W-1] sense_even_reg;
    logic [0:WORD_W-1] sense_odd_reg;
    logic [0:WORD_W-1] latch_reg;
    logic [0:CREG_W-1] creg_reg;
    logic [BOARD_W-1:0] board_reg;
    logic [DRV_GATES-1:0] gate_reg;
    logic [ROW_LINES-1:0] row_reg;
    logic module_reg;
    logic fault_reg;

    logic readout;
    logic strobe;
    logic latch_reset;
    logic mod_sel;
    logic [ADDR_W-1:0] word_idx;
    logic [ADDR_W-1:0] even_idx;
    logic [ADDR_W-1:0] odd_idx;
    logic [ROW_LINES-1:0] row0;
    logic [ROW_LINES-1:0] row1;
    logic [DRV_GATES-1:0] gate0;
    logic [DRV_GATES-1:0] gate1;
    logic [BOARD_W-1:0] board0;
    logic [BOARD_W-1:0] board1;
    logic hit0;
    logic hit1;
    logic drive_any;

    // ---- machine cycle timing ----
    always_comb begin
        case (phase_reg)
            PH_ONE: phase_next = PH_TWO;
            PH_TWO: phase_next = PH_THREE;
            PH_THREE: phase_next = PH_FOUR;
            PH_FOUR: phase_next = PH_ONE;
            default: phase_next = PH_ONE;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            phase_reg <= PH_ONE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // readout time also yields the latch reset, ahead of the strobe
    assign readout = (phase_reg == PH_TWO);
    assign latch_reset = readout;
    assign strobe = (phase_reg == PH_THREE);

    // ---- address registers ----
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            addr_high_reg <= ADDR_RST;
            addr_low_reg <= ADDR_RST;
        end else if (phase_reg == PH_ONE) begin
            addr_high_reg <= ADDR_HIGH_I;
            addr_low_reg <= ADDR_LOW_I;
        end
    end

    assign mod_sel = addr_high_reg[HI_MODULE_BIT];
    assign word_idx = {addr_high_reg[3:7], addr_low_reg};
    assign even_idx = {word_idx[ADDR_W-1:1], 1'b0};
    assign odd_idx = {word_idx[ADDR_W-1:1], 1'b1};

    // ---- one decode network per module ----
    csrd_decode u_dec_first (
        .enable_i (~mod_sel),
        .readout_i (readout),
        .high_i (addr_high_reg),
        .low_i (addr_low_reg),
        .row_o (row0),
        .gate_o (gate0),
        .board_o (board0),
        .hit_o (hit0)
    );

    csrd_decode u_dec_second (
        .enable_i (mod_sel),
        .readout_i (readout),
        .high_i (addr_high_reg),
        .low_i (addr_low_reg),
        .row_o (row1),
        .gate_o (gate1),
        .board_o (board1),
        .hit_o (hit1)
    );

    assign drive_any = hit0 | hit1;

    // ---- word store, written as card sets are placed ----
    // no reset: a real store is loaded by cards, not by the reset line
    always_ff @(posedge CLK_I) begin
        if (CARD_WR_I) begin
            store[CARD_ADDR_I] <= ~CARD_PUNCH_I;
        end
    end

    // ---- sensing: both words of the driven pair ----
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sense_even_reg <= WORD_RST;
            sense_odd_reg <= WORD_RST;
        end else if (readout) begin
            // an address with no board drives nothing and senses zero
            if (drive_any) begin
                sense_even_reg <= store[even_idx];
                sense_odd_reg <= store[odd_idx];
            end else begin
                sense_even_reg <= WORD_RST;
                sense_odd_reg <= WORD_RST;
            end
        end
    end

    // ---- word sense latches ----
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            latch_reg <= WORD_RST;
        end else if (latch_reset) begin
            latch_reg <= WORD_RST;
        end else if (strobe) begin
            latch_reg <= addr_low_reg[LO_WORD_BIT] ? sense_odd_reg
                : sense_even_reg;
        end
    end

    // ---- control registers: keep fields past the latch reset ----
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            creg_reg <= CREG_RST;
        end else if (phase_reg == PH_ONE) begin
            creg_reg <= CREG_RST;
        end else if (phase_reg == PH_TWO) begin
            creg_reg <= latch_reg[CREG_LO:CREG_HI];
        end
    end

    // ---- decode status, captured at readout time ----
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            board_reg <= BOARD_RST;
            gate_reg <= GATE_RST;
            row_reg <= ROW_RST;
            module_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else if (readout) begin
            board_reg <= board0 | board1;
            gate_reg <= gate0 | gate1;
            row_reg <= row0 | row1;
            module_reg <= mod_sel;
            fault_reg <= (hit0 & hit1) | ~$onehot(row0 | row1);
        end
    end

    assign LATCH_O = latch_reg;
    assign CTRL_REG_O = creg_reg;
    assign PHASE_O = phase_reg;
    assign BOARD_O = board_reg;
    assign GATE_O = gate_reg;
    assign ROW_SEL_O = row_reg;
    assign MODULE_O = module_reg;
    assign DRIVE_FAULT_O = fault_reg;

    // ---- checks ----
    logic [0:WORD_W-1] chk_word_reg;
    logic [11:0] mod_addr;

    assign mod_addr = word_idx[11:0];

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            chk_word_reg <= WORD_RST;
        end else if (readout) begin
            chk_word_reg <= drive_any ? store[word_idx] : WORD_RST;
        end
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_phase_order: assert property (
        phase_reg == PH_FOUR |=> phase_reg == PH_ONE ##1 phase_reg == PH_TWO)
        else $error("cycle phases out of order");

    a_addr_load_time: assert property (
        $changed(addr_low_reg) || $changed(addr_high_reg)
        |-> $past(phase_reg) == PH_ONE)
        else $error("address register changed outside phase one");

    a_row_one_line: assert property (
        readout |-> $onehot(row0 | row1) && ((row0 | row1) == 16'h0000)
        == 1'b0
        && (((|row0[15:8]) | (|row1[15:8])) == addr_low_reg[LO_HALF_BIT]))
        else $error("row-select lines not one-hot");

    a_row_idle: assert property (
        !readout |-> (row0 | row1) == ROW_RST && !drive_any)
        else $error("row line active outside readout time");

    a_board_range: assert property (
        readout |-> drive_any == (int'(mod_addr) <= MOD_LAST)
        && (hit1 == (drive_any && mod_sel)))
        else $error("module or address range decode wrong");

    a_board_map: assert property (
        readout && drive_any
        |-> int'(board0 | board1) == int'(mod_addr) / BOARD_WORDS
        && $onehot(gate0 | gate1))
        else $error("address maps to wrong board");

    a_gate_pick: assert property (
        readout && drive_any |-> int'($clog2(gate0 | gate1))
        == (int'(mod_addr) % BOARD_WORDS) / (2 * GATE_DRIVERS))
        else $error("wrong driver gate on board");

    a_one_driver: assert property (
        !(hit0 && hit1))
        else $error("drivers active in both modules");

    a_latch_word: assert property (
        phase_reg == PH_TWO |-> ##2 latch_reg == chk_word_reg
        && phase_reg == PH_FOUR)
        else $error("latched word is not the addressed word");

    a_latch_hold: assert property (
        $changed(latch_reg) |-> $past(phase_reg) inside {PH_TWO, PH_THREE})
        else $error("word latches changed without strobe or reset");

    a_creg_clear: assert property (
        phase_reg == PH_FOUR |-> ##2 creg_reg == CREG_RST)
        else $error("control registers not cleared in phase one");

    a_creg_copy: assert property (
        phase_reg == PH_FOUR |-> ##3
        creg_reg == $past(latch_reg[CREG_LO:CREG_HI], 3))
        else $error("control registers miss the latched field");

endmodule
